// ---- src/holding_regs.v ----
// eight-entry holding register file for table writes
`timescale 1ns/10ps
`include "tbl_exec_consts.vh"
module holding_regs #(
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire mclk,
   input wire rst,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [7:0] wr_data,
   input wire [AW-1:0] rd_addr,
   output reg [7:0] rd_data_ff
);
   reg [7:0] mem_ff [0:DEPTH-1];
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
         always @(posedge mclk or posedge rst) begin
            if (rst)
               mem_ff[gi] <= `HOLD_RST;
            else if (wr_en && wr_addr == gi)
               mem_ff[gi] <= wr_data; // only the holding reg changes, never the array
         end
      end
   endgenerate
   always @(posedge mclk or posedge rst) begin
      if (rst)
         rd_data_ff <= `BYTE_ZERO;
      else
         rd_data_ff <= mem_ff[rd_addr];
   end
endmodule // holding_regs

// ---- src/table_write_test_xor_exec.v ----
// execution unit for table write, test-skip-if-zero and xor literal
//
// Overview of operation
// - pointer low three bits pick holding register
// - eight holding regs; 0000_0000_0000_11nn decoded
// - post-increment: write old address, then advance
// - pre-increment: advance first; latch keeps value
// - decode 0110_011a; skip only when zero
// - skip discards fetched word, one nop cycle
// - skipping two-word instruction costs two nops
// - bank bit 0 selects access bank
// - bank bit 1 uses bank select reg
// - extended set, a=0: f<=5Fh indexed offset
// - xor accumulator with literal into accumulator
// - decode 0000_1010 kkkk_kkkk
// - xor updates only negative and zero
// - 21-bit pointer; bits 2:0 pick holding reg
`timescale 1ns/10ps
`include "tbl_exec_consts.vh"
module table_write_test_xor_exec #(
   parameter PTR_W = 21,
   parameter HOLD_DEPTH = 8,
   parameter HOLD_AW = 3
) (
   input wire mclk,
   input wire rst,
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire next_is_two_word,
   input wire ext_set_en,
   input wire [3:0] bank_select_reg,
   input wire [PTR_W-1:0] table_pointer_in,
   input wire table_pointer_load,
   input wire [7:0] table_latch,
   input wire [7:0] reg_rd_data,
   input wire [7:0] fsr2_low,
   input wire [HOLD_AW-1:0] hold_rd_addr,
   output reg [11:0] reg_rd_addr_ff,
   output reg reg_rd_indexed_ff,
   output reg [PTR_W-1:0] table_pointer_ff,
   output reg [7:0] acc_ff,
   output reg flag_n_ff,
   output reg flag_z_ff,
   output reg busy_ff,
   output reg discard_ff,
   output reg hold_we_ff,
   output wire [7:0] hold_rd_data
);
   // ****************************************
   // decode
   // ****************************************
   wire is_tblw = instr_valid && !busy_ff && instr_word[15:2] == `OP_TBLW_HI;
   wire is_tstz = instr_valid && !busy_ff && instr_word[15:9] == `OP_TSTZ_HI;
   wire is_xorl = instr_valid && !busy_ff && instr_word[15:8] == `OP_XORL_HI;
   // limitation: a request right after a test is taken; a skip cancels a table write there, but not an xor or a test
   wire bank_bit = instr_word[8];
   wire [7:0] faddr = instr_word[7:0];
   wire [7:0] xor_res = acc_ff ^ instr_word[7:0];
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [1:0] mode_ff;
   reg [HOLD_AW-1:0] wr_sel;
   reg [PTR_W-1:0] nxt_ptr;
   reg [3:0] abank;
   reg tst_pend_ff;
   reg two_word_ff;
   reg [11:0] nxt_rd_addr;
   reg nxt_indexed;
   // carry dropped on purpose: the register file adds the index high part
   wire [8:0] idx_full = {1'b0, fsr2_low} + {1'b0, faddr};
   wire [7:0] idx_sum = idx_full[7:0];
   // ****************************************
   // sequencer states
   // ****************************************
   localparam ST_IDLE = 2'h0;
   localparam ST_TBLW2 = 2'h1;
   localparam ST_SKIP1 = 2'h2;
   localparam ST_SKIP2 = 2'h3;
   // ****************************************
   // register address formation
   // ****************************************
   always @* begin
      abank = (faddr >= `ACCESS_HI_BASE) ? `ACCESS_HI_BANK : `ACCESS_LO_BANK;
   end
   always @* begin
      nxt_rd_addr = reg_rd_addr_ff;
      nxt_indexed = reg_rd_indexed_ff;
      if (is_tstz) begin
         if (bank_bit) begin
            nxt_rd_addr = {bank_select_reg, faddr};
            nxt_indexed = 1'b0;
         end else if (ext_set_en && faddr <= `IDX_LIMIT) begin
            nxt_rd_addr = {`IDX_BANK, idx_sum};
            nxt_indexed = 1'b1;
         end else begin
            nxt_rd_addr = {abank, faddr};
            nxt_indexed = 1'b0;
         end
      end
   end
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rd_addr_ff <= `RD_ADDR_RST;
         reg_rd_indexed_ff <= 1'b0;
      end else begin
         reg_rd_addr_ff <= nxt_rd_addr;
         reg_rd_indexed_ff <= nxt_indexed;
      end
   end
   // test bookkeeping: data comes back one cycle after the address
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         tst_pend_ff <= 1'b0;
         two_word_ff <= 1'b0;
      end else begin
         tst_pend_ff <= is_tstz;
         if (is_tstz)
            two_word_ff <= next_is_two_word;
      end
   end
   // ****************************************
   // sequencer
   // ****************************************
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (is_tblw)
               nxt_state = ST_TBLW2;
         end
         ST_TBLW2: nxt_state = ST_IDLE;
         ST_SKIP1: nxt_state = two_word_ff ? ST_SKIP2 : ST_IDLE;
         ST_SKIP2: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
      // data arrives one cycle after the address; decide skip then
      if (tst_pend_ff && reg_rd_data == `BYTE_ZERO)
         nxt_state = ST_SKIP1;
   end
   // ****************************************
   // table pointer and holding write select
   // ****************************************
   always @* begin
      nxt_ptr = table_pointer_ff;
      wr_sel = table_pointer_ff[HOLD_AW-1:0];
      case (mode_ff)
         `MODE_NONE: nxt_ptr = table_pointer_ff;
         `MODE_POSTINC: nxt_ptr = table_pointer_ff + `PTR_ONE;
         `MODE_POSTDEC: nxt_ptr = table_pointer_ff - `PTR_ONE;
         `MODE_PREINC: begin
            nxt_ptr = table_pointer_ff + `PTR_ONE;
            wr_sel = nxt_ptr[HOLD_AW-1:0];
         end
         default: nxt_ptr = table_pointer_ff;
      endcase
   end
   wire hold_we = (state_ff == ST_TBLW2); // latch sampled in second cycle
   // ****************************************
   // sequencer state and cycle flags
   // ****************************************
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         busy_ff <= 1'b0;
         discard_ff <= 1'b0;
         hold_we_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         busy_ff <= (nxt_state != ST_IDLE);
         discard_ff <= (nxt_state == ST_SKIP1) || (nxt_state == ST_SKIP2);
         hold_we_ff <= hold_we;
      end
   end
   // ****************************************
   // table write mode and pointer
   // ****************************************
   always @(posedge mclk or posedge rst) begin
      if (rst)
         mode_ff <= `MODE_NONE;
      else if (is_tblw)
         mode_ff <= instr_word[1:0];
   end
   // the write's own update wins over a host load in the same cycle
   always @(posedge mclk or posedge rst) begin
      if (rst)
         table_pointer_ff <= `PTR_RST;
      else if (hold_we)
         table_pointer_ff <= nxt_ptr;
      else if (table_pointer_load)
         table_pointer_ff <= table_pointer_in;
   end
   // ****************************************
   // accumulator and status flags
   // ****************************************
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         acc_ff <= `ACC_RST;
         flag_n_ff <= 1'b0;
         flag_z_ff <= 1'b0;
      end else if (is_xorl) begin
         acc_ff <= xor_res;
         flag_n_ff <= xor_res[7];
         flag_z_ff <= (xor_res == `BYTE_ZERO);
      end
   end
   // ****************************************
   // holding registers
   // ****************************************
   holding_regs #(
      .DEPTH(HOLD_DEPTH),
      .AW(HOLD_AW)
   ) u_hold (
      .mclk(mclk),
      .rst(rst),
      .wr_en(hold_we),
      .wr_addr(wr_sel),
      .wr_data(table_latch), // latch is only read, never altered
      .rd_addr(hold_rd_addr),
      .rd_data_ff(hold_rd_data)
   );
endmodule // table_write_test_xor_exec

// ---- src/tbl_exec_consts.vh ----
// constants for the table write, test-skip and xor-literal execution block
`ifndef TBL_EXEC_CONSTS_VH
`define TBL_EXEC_CONSTS_VH
`define OP_TBLW_HI 14'h0003
`define OP_TSTZ_HI 7'h33
`define OP_XORL_HI 8'h0A
`define MODE_NONE 2'h0
`define MODE_POSTINC 2'h1
`define MODE_POSTDEC 2'h2
`define MODE_PREINC 2'h3
`define PTR_RST 21'h000000
`define PTR_ONE 21'h000001
`define ACC_RST 8'h00
`define BYTE_ZERO 8'h00
`define IDX_LIMIT 8'h5F
`define ACCESS_HI_BASE 8'h60
`define ACCESS_HI_BANK 4'hF
`define ACCESS_LO_BANK 4'h0
`define IDX_BANK 4'h0
`define RD_ADDR_RST 12'h000
`define HOLD_RST 8'hFF
`endif

// ---- verif/table_write_test_xor_exec_tb.sv ----
// self-checking bench for the execution block
`timescale 1ns/10ps
module table_write_test_xor_exec_tb;
   reg mclk, rst, instr_valid, next_is_two_word, ext_set_en, table_pointer_load;
   reg [15:0] instr_word;
   reg [3:0] bank_select_reg;
   reg [20:0] table_pointer_in;
   reg [7:0] table_latch, reg_rd_data, fsr2_low, f;
   reg [2:0] hold_rd_addr;
   wire [11:0] reg_rd_addr_ff;
   wire reg_rd_indexed_ff, flag_n_ff, flag_z_ff, busy_ff, discard_ff, hold_we_ff;
   wire [20:0] table_pointer_ff;
   wire [7:0] acc_ff, hold_rd_data;
   integer err_count, n_checks, seed, i, n, acc, ptr;
   reg [7:0] hold [0:7];
   reg [12:0] ea;
   table_write_test_xor_exec dut (
      .mclk(mclk),
      .rst(rst),
      .instr_valid(instr_valid),
      .instr_word(instr_word),
      .next_is_two_word(next_is_two_word),
      .ext_set_en(ext_set_en),
      .bank_select_reg(bank_select_reg),
      .table_pointer_in(table_pointer_in),
      .table_pointer_load(table_pointer_load),
      .table_latch(table_latch),
      .reg_rd_data(reg_rd_data),
      .fsr2_low(fsr2_low),
      .hold_rd_addr(hold_rd_addr),
      .reg_rd_addr_ff(reg_rd_addr_ff),
      .reg_rd_indexed_ff(reg_rd_indexed_ff),
      .table_pointer_ff(table_pointer_ff),
      .acc_ff(acc_ff),
      .flag_n_ff(flag_n_ff),
      .flag_z_ff(flag_z_ff),
      .busy_ff(busy_ff),
      .discard_ff(discard_ff),
      .hold_we_ff(hold_we_ff),
      .hold_rd_data(hold_rd_data)
   );
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task chk(input [31:0] got, input [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task issue(input [15:0] w);
      @(posedge mclk);
      #1 instr_valid = 1'b1;
      instr_word = w;
      @(posedge mclk);
      #1 instr_valid = 1'b0;
   endtask
   task test_done;
      if (err_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #50000 err_count++;
      test_done;
   end
   initial begin
      {rst, instr_valid, next_is_two_word, ext_set_en, table_pointer_load} = 5'h10;
      {instr_word, bank_select_reg, table_pointer_in, table_latch, reg_rd_data, fsr2_low} = 0;
      hold_rd_addr = 3'h0;
      {err_count, n_checks, acc} = 0;
      seed = 32'h7FC9;
      for (i = 0; i < 8; i++) hold[i] = 8'hFF;
      repeat (3) @(posedge mclk);
      #1 rst = 1'b0;
      for (i = 0; i < 20; i++) begin
         f = (i == 7) ? acc : $random(seed);
         issue({8'h0A, f});
         acc = acc ^ f;
         chk(acc_ff, acc);
         chk({flag_n_ff, flag_z_ff}, {acc[7], acc == 0});
      end
      table_pointer_in = $random(seed);
      table_pointer_load = 1'b1;
      ptr = table_pointer_in;
      @(posedge mclk);
      #1 table_pointer_load = 1'b0;
      for (i = 0; i < 16; i++) begin
         table_latch = $random(seed);
         if (i % 4 == 3) ptr = (ptr + 1) & 32'h1FFFFF;
         hold[ptr[2:0]] = table_latch;
         if (i % 4 == 1) ptr = (ptr + 1) & 32'h1FFFFF;
         if (i % 4 == 2) ptr = (ptr - 1) & 32'h1FFFFF;
         issue({14'h0003, i[1:0]});
         chk({busy_ff, hold_we_ff}, 2'h2);
         @(posedge mclk);
         #1 chk(table_pointer_ff, ptr);
         chk({busy_ff, hold_we_ff}, 2'h1);
      end
      for (i = 0; i < 8; i++) begin
         hold_rd_addr = i;
         @(posedge mclk);
         #1 chk(hold_rd_data, hold[i]);
      end
      for (i = 0; i < 24; i++) begin
         f = $random(seed);
         {bank_select_reg, fsr2_low, ext_set_en, next_is_two_word} = $random(seed);
         reg_rd_data = (i % 3 == 0) ? 8'h00 : f | 8'h01;
         issue({7'h33, i[0], f});
         if (i[0]) ea = {1'b0, bank_select_reg, f};
         else if (ext_set_en && f <= 8'h5F) ea = {5'h10, fsr2_low + f};
         else ea = {1'b0, (f >= 8'h60) ? 4'hF : 4'h0, f};
         if (i[0]) chk({reg_rd_indexed_ff, reg_rd_addr_ff}, ea);
         else if (ea[12]) chk({reg_rd_indexed_ff, reg_rd_addr_ff}, ea);
         else chk({reg_rd_indexed_ff, reg_rd_addr_ff}, ea);
         n = 0;
         repeat (3) begin
            @(posedge mclk);
            #1 if (discard_ff === 1'b1) n++;
         end
         chk(n, (reg_rd_data != 0) ? 0 : next_is_two_word ? 2 : 1);
      end
      test_done;
   end
endmodule // table_write_test_xor_exec_tb

// ---- verif/tbl_exec_sva.sv ----
// assertion checker for the execution block
`timescale 1ns/10ps
module tbl_exec_sva (
   input wire mclk,
   input wire rst,
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire next_is_two_word,
   input wire [3:0] bank_select_reg,
   input wire [7:0] reg_rd_data,
   input wire [11:0] reg_rd_addr_ff,
   input wire [20:0] table_pointer_ff,
   input wire [7:0] acc_ff,
   input wire flag_n_ff,
   input wire flag_z_ff,
   input wire busy_ff,
   input wire discard_ff
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // requests while busy are dropped, so only idle cycles count
   wire tk = instr_valid && !busy_ff;
   wire xo = tk && instr_word[15:8] == 8'h0A;
   wire tw = tk && instr_word[15:2] == 14'h0003;
   wire ts = tk && instr_word[15:9] == 7'h33;
   a_xor_acc: assert property (xo |=> acc_ff == ($past(acc_ff) ^ $past(instr_word[7:0])))
      else $error("xor result wrong");
   a_xor_flags: assert property (xo |=>
      flag_n_ff == acc_ff[7] && flag_z_ff == (acc_ff == 8'h00)) else $error("xor flags wrong");
   a_tblw_two: assert property (tw |=> busy_ff ##1 !busy_ff)
      else $error("table write length wrong");
   a_ptr_inc: assert property (tw && instr_word[0] |->
      ##2 table_pointer_ff == $past(table_pointer_ff, 2) + 21'h000001) else $error("ptr inc wrong");
   a_ptr_dec: assert property (tw && instr_word[1:0] == 2'h2 |->
      ##2 table_pointer_ff == $past(table_pointer_ff, 2) - 21'h000001) else $error("ptr dec wrong");
   a_skip_one: assert property (ts && !next_is_two_word ##1 reg_rd_data == 8'h00 |=>
      discard_ff && busy_ff ##1 !discard_ff) else $error("single skip wrong");
   a_skip_two: assert property (ts && next_is_two_word ##1 reg_rd_data == 8'h00 |=>
      discard_ff [*2] ##1 !discard_ff) else $error("double skip wrong");
   a_no_skip: assert property (ts ##1 reg_rd_data != 8'h00 |=> !discard_ff)
      else $error("skip on nonzero");
   a_bank_addr: assert property (ts && instr_word[8] |=>
      reg_rd_addr_ff == {$past(bank_select_reg), $past(instr_word[7:0])}) else $error("bank addr");
endmodule // tbl_exec_sva
bind table_write_test_xor_exec tbl_exec_sva u_sva (
   .mclk(mclk),
   .rst(rst),
   .instr_valid(instr_valid),
   .instr_word(instr_word),
   .next_is_two_word(next_is_two_word),
   .bank_select_reg(bank_select_reg),
   .reg_rd_data(reg_rd_data),
   .reg_rd_addr_ff(reg_rd_addr_ff),
   .table_pointer_ff(table_pointer_ff),
   .acc_ff(acc_ff),
   .flag_n_ff(flag_n_ff),
   .flag_z_ff(flag_z_ff),
   .busy_ff(busy_ff),
   .discard_ff(discard_ff)
);
